// ### rtl/headset_detect_pkg.sv
// Shared constants and types of the headset detector register group.
`default_nettype none
package headset_detect_pkg;

	// ==========================================================
	// Register offsets on the two-wire bus.
	localparam logic [7:0] DETECT_CONTROL_OFFSET        = 8'h04;
	localparam logic [7:0] HEADSET_DETECT_RESULT_OFFSET = 8'h05;
	localparam logic [7:0] DETECT_EVENT_FLAGS_OFFSET    = 8'h06;
	localparam logic [7:0] DETECT_EVENT_MASKS_OFFSET    = 8'h07;
	localparam logic [7:0] REG_RESET_VALUE              = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE          = 8'h00;

	// ==========================================================
	// Field positions.
	localparam int GROUND_BAND_LOCATION_BIT = 6;
	localparam int SLEEVE_BIN_LSB           = 3;
	localparam int RING2_BIN_LSB            = 0;
	localparam int DETECTION_FAILED_BIT     = 3;
	localparam int MICROPHONE_FOUND_BIT     = 1;
	localparam int THREE_BAND_HEADSET_BIT   = 0;
	localparam int INDICATOR_TRISTATE_BIT   = 4;
	localparam int INTERRUPT_MODE_BIT       = 2;
	localparam int AUTO_SWITCH_DISABLE_BIT  = 1;
	localparam int HOST_TRIGGER_BIT         = 0;
	localparam logic [7:0] EVENT_FLAGS_USED = 8'h0B;
	localparam logic [7:0] EVENT_MASKS_USED = 8'h1B;
	localparam logic [7:0] CONTROL_USED     = 8'h06;

	// ==========================================================
	// Impedance bins and classification.
	localparam int              BIN_WIDTH      = 3;
	localparam int              BIN_COUNT      = 8;
	localparam logic [15:0]     BIN_STEP_OHMS  = 16'h0190;
	localparam logic [2:0]      BIN_SHORT      = 3'h0;
	localparam logic [2:0]      BIN_OPEN       = 3'h7;

	// ==========================================================
	// Two-wire bus slave.
	localparam logic [6:0] SLAVE_ADDRESS_LOW  = 7'h3B;
	localparam logic [6:0] SLAVE_ADDRESS_HIGH = 7'h3C;
	localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

	typedef enum logic [3:0] {
		BUS_IDLE     = 4'b0000,
		BUS_ADDR     = 4'b0001,
		BUS_ADDR_ACK = 4'b0010,
		BUS_REG      = 4'b0011,
		BUS_REG_ACK  = 4'b0100,
		BUS_WDATA    = 4'b0101,
		BUS_WDATA_ACK= 4'b0110,
		BUS_RDATA    = 4'b0111,
		BUS_RDATA_ACK= 4'b1000
	} bus_phase_t;

	typedef enum logic [2:0] {
		DET_IDLE      = 3'b000,
		DET_MEAS_TS   = 3'b001,
		DET_WAIT_TS   = 3'b010,
		DET_MEAS_TR   = 3'b011,
		DET_WAIT_TR   = 3'b100,
		DET_CLASSIFY  = 3'b101
	} det_state_t;

endpackage
`default_nettype wire

// ### rtl/headset_detect_status_regs.sv
// Detection sequencer, result registers and two-wire bus slave of the headset detector.
`timescale 1ns/1ps
`default_nettype none
module headset_detect_status_regs (
	// Clock, reset and enable.
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// Two-wire bus pins, open drain.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_drive_n,
	input  wire logic        addr_sel,
	// Detection trigger pin.
	input  wire logic        det_trigger,
	// Analog measurement front end, same clock.
	output logic             measure_start,
	output logic             measure_ring2,
	input  wire logic        measure_done,
	input  wire logic [15:0] measure_ohms,
	// Switch routing.
	output logic             mic_to_ring2,
	output logic             mic_to_sleeve,
	output logic             gnd_to_ring2,
	output logic             gnd_to_sleeve,
	// Microphone indicator pin, open drain, and host interrupt.
	output logic             microphone_indicator_out,
	output logic             microphone_indicator_drive_n,
	output logic             host_irq
);
	typedef struct packed {
		headset_detect_pkg::bus_phase_t bus_phase;
		logic [3:0]                     bit_count;
		logic [7:0]                     shift;
		logic [7:0]                     reg_pointer;
		logic                           is_read;
		logic                           sda_drive_n;
		logic                           scl_prev;
		logic                           sda_prev;
		headset_detect_pkg::det_state_t det_state;
		logic                           measure_start;
		logic                           measure_ring2;
		logic [2:0]                     sleeve_bin;
		logic [2:0]                     ring2_bin;
		logic                           trigger_prev;
		logic [7:0]                     detection_result_register;
		logic [7:0]                     event_flags;
		logic [7:0]                     event_masks;
		logic [7:0]                     control;
		logic                           microphone_present;
		logic                           mic_to_ring2;
		logic                           mic_to_sleeve;
		logic                           gnd_to_ring2;
		logic                           gnd_to_sleeve;
		logic                           indicator_drive_n;
	} regs_state_t;

	regs_state_t state;
	regs_state_t next_state;

	logic [2:0] synced;
	logic       scl_s;
	logic       sda_s;
	logic       trigger_s;
	logic [2:0] measured_bin;
	logic [7:0] read_value;
	logic       irq_level;

	// ==========================================================
	// Bus and trigger pin inputs pass two flip-flops before any logic reads them; addr_sel is read directly.
	pin_sync #(
		.WIDTH      (3)
	) u_pin_sync (
		.core_clk   (core_clk),
		.rst        (rst),
		.ce         (ce),
		.pin_level  ({scl_in, sda_in, det_trigger}),
		.sync_level (synced)
	);
	assign scl_s     = synced[2];
	assign sda_s     = synced[1];
	assign trigger_s = synced[0];

	// Each measurement result is binned the same way for both bands.
	impedance_bin u_impedance_bin (
		.impedance_ohms (measure_ohms),
		.bin_code       (measured_bin)
	);

	// ==========================================================
	// Read multiplexer; unmapped addresses read as zero.
	always_comb
	begin
		case (state.reg_pointer)
			headset_detect_pkg::DETECT_CONTROL_OFFSET:        read_value = state.control;
			headset_detect_pkg::HEADSET_DETECT_RESULT_OFFSET: read_value = state.detection_result_register;
			headset_detect_pkg::DETECT_EVENT_FLAGS_OFFSET:    read_value = state.event_flags;
			headset_detect_pkg::DETECT_EVENT_MASKS_OFFSET:    read_value = state.event_masks;
			default:                                          read_value = headset_detect_pkg::UNMAPPED_READ_VALUE;
		endcase
	end

	// Unmasked flags are ORed onto the interrupt.
	assign irq_level = |(state.event_flags & ~state.event_masks & headset_detect_pkg::EVENT_FLAGS_USED);

	// ==========================================================
	// Next-state logic of bus slave, sequencer and routing.
	always_comb
	begin
		logic       scl_rise;
		logic       scl_fall;
		logic       bus_start;
		logic       bus_stop;
		logic       wr_strobe;
		logic       rd_strobe;
		logic       host_trigger;
		logic       pin_trigger;
		logic [7:0] set_flags;
		logic [7:0] clr_flags;
		logic       lower_sleeve;
		logic [2:0] low_bin;
		logic [2:0] high_bin;
		logic       three_band;
		logic       mic_found;

		next_state   = state;
		scl_rise     = scl_s & ~state.scl_prev;
		scl_fall     = ~scl_s & state.scl_prev;
		bus_start    = scl_s & state.scl_prev & state.sda_prev & ~sda_s;
		bus_stop     = scl_s & state.scl_prev & ~state.sda_prev & sda_s;
		wr_strobe    = 1'b0;
		rd_strobe    = 1'b0;
		host_trigger = 1'b0;
		pin_trigger  = trigger_s & ~state.trigger_prev;
		set_flags    = 8'h00;
		clr_flags    = 8'h00;
		lower_sleeve = 1'b0;
		low_bin      = 3'h0;
		high_bin     = 3'h0;
		three_band   = 1'b0;
		mic_found    = 1'b0;

		next_state.scl_prev      = scl_s;
		next_state.sda_prev      = sda_s;
		next_state.trigger_prev  = trigger_s;
		next_state.measure_start = 1'b0;

		// Bus slave: data sampled on SCL rise, driven after SCL fall.
		if (bus_start)
		begin
			next_state.bus_phase   = headset_detect_pkg::BUS_ADDR;
			next_state.bit_count   = 4'h0;
			next_state.sda_drive_n = 1'b1;
		end
		else if (bus_stop)
		begin
			next_state.bus_phase   = headset_detect_pkg::BUS_IDLE;
			next_state.sda_drive_n = 1'b1;
		end
		else if (scl_rise)
		begin
			case (state.bus_phase)
				headset_detect_pkg::BUS_ADDR, headset_detect_pkg::BUS_REG,
				headset_detect_pkg::BUS_WDATA:
				begin
					next_state.shift     = {state.shift[6:0], sda_s};
					next_state.bit_count = state.bit_count + 4'h1;
				end
				headset_detect_pkg::BUS_RDATA:
					next_state.bit_count = state.bit_count + 4'h1;
				headset_detect_pkg::BUS_RDATA_ACK:
					if (sda_s)
						next_state.bus_phase = headset_detect_pkg::BUS_IDLE; // Master ends the burst.
				default:
					next_state.bus_phase = state.bus_phase;
			endcase
		end
		else if (scl_fall)
		begin
			case (state.bus_phase)
				headset_detect_pkg::BUS_ADDR:
					if (state.bit_count == headset_detect_pkg::BITS_PER_BYTE)
					begin
						if (state.shift[7:1] == (addr_sel ? headset_detect_pkg::SLAVE_ADDRESS_HIGH
						                                  : headset_detect_pkg::SLAVE_ADDRESS_LOW))
						begin
							next_state.is_read     = state.shift[0];
							next_state.bus_phase   = headset_detect_pkg::BUS_ADDR_ACK;
							next_state.sda_drive_n = 1'b0;
						end
						else
							next_state.bus_phase = headset_detect_pkg::BUS_IDLE;
					end
				headset_detect_pkg::BUS_REG:
					if (state.bit_count == headset_detect_pkg::BITS_PER_BYTE)
					begin
						next_state.reg_pointer = state.shift;
						next_state.bus_phase   = headset_detect_pkg::BUS_REG_ACK;
						next_state.sda_drive_n = 1'b0;
					end
				headset_detect_pkg::BUS_WDATA:
					if (state.bit_count == headset_detect_pkg::BITS_PER_BYTE)
					begin
						wr_strobe              = 1'b1;
						next_state.bus_phase   = headset_detect_pkg::BUS_WDATA_ACK;
						next_state.sda_drive_n = 1'b0;
					end
				headset_detect_pkg::BUS_ADDR_ACK, headset_detect_pkg::BUS_RDATA_ACK:
				begin
					next_state.bit_count = 4'h0;
					if (state.is_read)
					begin
						// Burst reads advance the pointer after each byte.
						rd_strobe              = 1'b1;
						next_state.shift       = read_value;
						next_state.sda_drive_n = read_value[7];
						next_state.reg_pointer = state.reg_pointer + 8'h01;
						next_state.bus_phase   = headset_detect_pkg::BUS_RDATA;
					end
					else
					begin
						next_state.sda_drive_n = 1'b1;
						next_state.bus_phase   = headset_detect_pkg::BUS_REG;
					end
				end
				headset_detect_pkg::BUS_REG_ACK, headset_detect_pkg::BUS_WDATA_ACK:
				begin
					next_state.bit_count   = 4'h0;
					next_state.sda_drive_n = 1'b1;
					next_state.bus_phase   = headset_detect_pkg::BUS_WDATA;
				end
				headset_detect_pkg::BUS_RDATA:
					if (state.bit_count == headset_detect_pkg::BITS_PER_BYTE)
					begin
						next_state.sda_drive_n = 1'b1;
						next_state.bus_phase   = headset_detect_pkg::BUS_RDATA_ACK;
					end
					else
					begin
						next_state.sda_drive_n = state.shift[6];
						next_state.shift       = {state.shift[6:0], 1'b0};
					end
				default:
					next_state.bus_phase = state.bus_phase;
			endcase
		end

		// Register writes; the event flag and result registers ignore writes.
		if (wr_strobe)
		begin
			if (state.reg_pointer == headset_detect_pkg::DETECT_EVENT_MASKS_OFFSET)
				next_state.event_masks = state.shift & headset_detect_pkg::EVENT_MASKS_USED;
			else if (state.reg_pointer == headset_detect_pkg::DETECT_CONTROL_OFFSET)
			begin
				next_state.control = state.shift & headset_detect_pkg::CONTROL_USED;
				host_trigger       = state.shift[headset_detect_pkg::HOST_TRIGGER_BIT];
			end
			next_state.reg_pointer = state.reg_pointer + 8'h01;
		end

		// Detection sequencer: tip-sleeve first, then tip-ring2, then classify.
		case (state.det_state)
			headset_detect_pkg::DET_IDLE:
				if (pin_trigger | host_trigger)
					next_state.det_state = headset_detect_pkg::DET_MEAS_TS;
			headset_detect_pkg::DET_MEAS_TS:
			begin
				next_state.measure_start = 1'b1;
				next_state.measure_ring2 = 1'b0;
				next_state.det_state     = headset_detect_pkg::DET_WAIT_TS;
			end
			headset_detect_pkg::DET_WAIT_TS:
				if (measure_done)
				begin
					next_state.sleeve_bin = measured_bin;
					next_state.det_state  = headset_detect_pkg::DET_MEAS_TR;
				end
			headset_detect_pkg::DET_MEAS_TR:
			begin
				next_state.measure_start = 1'b1;
				next_state.measure_ring2 = 1'b1;
				next_state.det_state     = headset_detect_pkg::DET_WAIT_TR;
			end
			headset_detect_pkg::DET_WAIT_TR:
				if (measure_done)
				begin
					next_state.ring2_bin = measured_bin;
					next_state.det_state = headset_detect_pkg::DET_CLASSIFY;
				end
			headset_detect_pkg::DET_CLASSIFY:
			begin
				// Equal bins mean the two bands are shorted together.
				lower_sleeve = state.sleeve_bin < state.ring2_bin;
				low_bin      = lower_sleeve ? state.sleeve_bin : state.ring2_bin;
				high_bin     = lower_sleeve ? state.ring2_bin : state.sleeve_bin;
				three_band   = state.sleeve_bin == state.ring2_bin;
				mic_found    = ~three_band & (low_bin < high_bin) & (high_bin != headset_detect_pkg::BIN_OPEN)
				               & (high_bin != headset_detect_pkg::BIN_SHORT);
				next_state.detection_result_register = 8'h00;
				next_state.detection_result_register[headset_detect_pkg::GROUND_BAND_LOCATION_BIT] =
					lower_sleeve | three_band;
				next_state.detection_result_register[headset_detect_pkg::SLEEVE_BIN_LSB +: 3] =
					state.sleeve_bin;
				next_state.detection_result_register[headset_detect_pkg::RING2_BIN_LSB +: 3] =
					state.ring2_bin;
				set_flags[headset_detect_pkg::THREE_BAND_HEADSET_BIT] = three_band;
				set_flags[headset_detect_pkg::MICROPHONE_FOUND_BIT]   = mic_found;
				set_flags[headset_detect_pkg::DETECTION_FAILED_BIT]   = ~three_band & ~mic_found;
				next_state.microphone_present = mic_found;
				if (!state.control[headset_detect_pkg::AUTO_SWITCH_DISABLE_BIT])
				begin
					next_state.mic_to_ring2  = mic_found & lower_sleeve;
					next_state.mic_to_sleeve = mic_found & ~lower_sleeve;
					next_state.gnd_to_sleeve = (mic_found | three_band) & (lower_sleeve | three_band);
					next_state.gnd_to_ring2  = (mic_found | three_band) & (~lower_sleeve | three_band);
				end
				next_state.det_state = headset_detect_pkg::DET_IDLE;
			end
			default:
				next_state.det_state = headset_detect_pkg::DET_IDLE;
		endcase

		// Reading the event register clears it, but a new event wins.
		if (rd_strobe && state.reg_pointer == headset_detect_pkg::DETECT_EVENT_FLAGS_OFFSET)
			clr_flags = headset_detect_pkg::EVENT_FLAGS_USED;
		next_state.event_flags = (state.event_flags & ~clr_flags) | set_flags;

		// Indicator: tri-state, interrupt use, or microphone presence.
		if (state.event_masks[headset_detect_pkg::INDICATOR_TRISTATE_BIT])
			next_state.indicator_drive_n = 1'b1;
		else if (state.control[headset_detect_pkg::INTERRUPT_MODE_BIT])
			next_state.indicator_drive_n = ~irq_level;
		else
			next_state.indicator_drive_n = ~state.microphone_present;
	end

	// ==========================================================
	// State registers; reset clears them to zero, except the SDA and indicator drive enables and previous bus levels, which load one.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state                           <= '0;
			state.bus_phase                 <= headset_detect_pkg::BUS_IDLE;
			state.det_state                 <= headset_detect_pkg::DET_IDLE;
			state.sda_drive_n               <= 1'b1;
			state.scl_prev                  <= 1'b1;
			state.sda_prev                  <= 1'b1;
			state.indicator_drive_n         <= 1'b1;
			state.detection_result_register <= headset_detect_pkg::REG_RESET_VALUE;
			state.event_flags               <= headset_detect_pkg::REG_RESET_VALUE;
			state.event_masks               <= headset_detect_pkg::REG_RESET_VALUE;
		end
		else if (ce)
			state <= next_state;
	end

	// ==========================================================
	// Outputs. Open-drain pins only ever pull low.
	assign sda_out                      = 1'b0;
	assign sda_drive_n                  = state.sda_drive_n;
	assign measure_start                = state.measure_start;
	assign measure_ring2                = state.measure_ring2;
	assign mic_to_ring2                 = state.mic_to_ring2;
	assign mic_to_sleeve                = state.mic_to_sleeve;
	assign gnd_to_ring2                 = state.gnd_to_ring2;
	assign gnd_to_sleeve                = state.gnd_to_sleeve;
	assign microphone_indicator_out     = 1'b0;
	assign microphone_indicator_drive_n = state.indicator_drive_n;
	assign host_irq                     = irq_level;
endmodule // headset_detect_status_regs
`default_nettype wire

// ### rtl/impedance_bin.sv
// Quantiser of a measured impedance into a 3-bit bin.
`timescale 1ns/1ps
`default_nettype none
module impedance_bin (
	// Measured value in ohms.
	input  wire logic [15:0] impedance_ohms,
	// Bin code, saturating at the open code.
	output logic      [2:0]  bin_code
);
	// ==========================================================
	// Count how many bin edges lie at or below the value.
	always_comb
	begin
		bin_code = headset_detect_pkg::BIN_SHORT;
		for (int k = 1; k < headset_detect_pkg::BIN_COUNT; k++)
		begin
			if ({4'h0, impedance_ohms} >= 20'(k) * {4'h0, headset_detect_pkg::BIN_STEP_OHMS})
				bin_code = 3'(k);
		end
	end
endmodule // impedance_bin
`default_nettype wire

// ### rtl/pin_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock, reset and enable.
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Pin side and synchronised side.
	input  wire logic [WIDTH-1:0] pin_level,
	output logic      [WIDTH-1:0] sync_level
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	// ==========================================================
	// The first stage feeds only the second stage.
	always_comb
	begin
		next_state        = state;
		next_state.first  = pin_level;
		next_state.second = state.first;
	end

	// Registers; reset takes constants only.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state <= '0;
		else if (ce)
			state <= next_state;
	end

	assign sync_level = state.second;
endmodule // pin_sync
`default_nettype wire

// ### testbench/headset_detect_chk.sv
// Concurrent checks on the pins of the headset detector register group.
`timescale 1ns/1ps
`default_nettype none
module headset_detect_chk (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Watched pins.
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_drive_n,
	input wire logic measure_start,
	input wire logic measure_ring2,
	input wire logic measure_done,
	input wire logic mic_to_ring2,
	input wire logic mic_to_sleeve,
	input wire logic gnd_to_ring2,
	input wire logic gnd_to_sleeve,
	input wire logic microphone_indicator_out
);
	// ==========================================================
	// One clock domain, so clocking and reset are declared once.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [3:0] sw;
	assign sw = {mic_to_ring2, mic_to_sleeve, gnd_to_ring2, gnd_to_sleeve};
	sequence ts_done_s; measure_done && !measure_ring2; endsequence
	sequence tr_start_s; measure_start && measure_ring2; endsequence
	// The second step must follow the first or the bins get swapped.
	step_order_a: assert property (ts_done_s |-> ##[1:2] tr_start_s)
		else $error("ring2 step did not follow sleeve step");
	start_pulse_a: assert property (measure_start |=> !measure_start)
		else $error("measure start longer than one cycle");
	mic_single_a: assert property (!(mic_to_ring2 && mic_to_sleeve))
		else $error("microphone on both bands");
	ring2_mic_a: assert property (mic_to_ring2 |-> gnd_to_sleeve && !gnd_to_ring2)
		else $error("ground not opposite ring2 microphone");
	sleeve_mic_a: assert property (mic_to_sleeve |-> gnd_to_ring2 && !gnd_to_sleeve)
		else $error("ground not opposite sleeve microphone");
	switch_time_a: assert property ($changed(sw) |-> $past(measure_done) || $past(measure_done, 2))
		else $error("switches moved outside a detection result");
	// The slave may only pull data low while the bus clock is low.
	sda_pull_a: assert property ($fell(sda_drive_n) |-> !scl_in)
		else $error("data pulled low while bus clock high");
	pin_zero_a: assert property (!sda_out && !microphone_indicator_out)
		else $error("open drain value not low");
endmodule // headset_detect_chk
bind headset_detect_status_regs headset_detect_chk chk (.core_clk(core_clk), .rst(rst),
	.scl_in(scl_in), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
	.measure_start(measure_start), .measure_ring2(measure_ring2), .measure_done(measure_done),
	.mic_to_ring2(mic_to_ring2), .mic_to_sleeve(mic_to_sleeve), .gnd_to_ring2(gnd_to_ring2),
	.gnd_to_sleeve(gnd_to_sleeve), .microphone_indicator_out(microphone_indicator_out));
`default_nettype wire

// ### testbench/tb_headset_detect_status_regs.sv
// Self-checking bench of the headset detector register group.
`timescale 1ns/1ps
`default_nettype none
module tb_headset_detect_status_regs;
	// ==========================================================
	// Signals and bookkeeping.
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        det_trigger = 1'b0;
	logic        measure_done = 1'b0;
	logic [15:0] measure_ohms = 16'h0000;
	logic [15:0] ohms_ts = 16'h0000;
	logic [15:0] ohms_tr = 16'h0000;
	logic [2:0]  fe_cnt = 3'h0;
	logic [31:0] seed = 32'hEDC8;
	logic [7:0]  exp_q[$];
	int          err_count = 0;
	int          tests_run = 0;
	wire logic   scl, sda_host, sda_line, sda_out, sda_drive_n, measure_start, measure_ring2;
	wire logic   ind_out, ind_n, host_irq, rd_valid;
	wire logic [3:0] sw;
	wire logic [7:0] rd_data;
	assign sda_line = sda_host & (sda_drive_n | sda_out);
	always #5 core_clk = ~core_clk;
	headset_detect_status_regs uut (.core_clk(core_clk), .rst(rst), .ce(1'b1),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_drive_n(sda_drive_n),
		.addr_sel(1'b0), .det_trigger(det_trigger), .measure_start(measure_start),
		.measure_ring2(measure_ring2), .measure_done(measure_done), .measure_ohms(measure_ohms),
		.mic_to_ring2(sw[3]), .mic_to_sleeve(sw[2]), .gnd_to_ring2(sw[1]), .gnd_to_sleeve(sw[0]),
		.microphone_indicator_out(ind_out), .microphone_indicator_drive_n(ind_n),
		.host_irq(host_irq));
	two_wire_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
		.sda_host(sda_host), .rd_data(rd_data), .rd_valid(rd_valid));
	// Front end answers three cycles after a start; between answers the value is junk.
	always @(posedge core_clk)
	begin
		if (measure_start === 1'b1)
			fe_cnt <= 3'h3;
		else if (fe_cnt != 3'h0)
			fe_cnt <= fe_cnt - 3'h1;
		measure_done <= (fe_cnt == 3'h1);
		measure_ohms <= (fe_cnt == 3'h1) ? (measure_ring2 ? ohms_tr : ohms_ts) : ~measure_ohms;
	end
	// ==========================================================
	// Checking and closing.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Each read byte is compared with the oldest expectation noted by the driver.
	always @(posedge core_clk)
	begin
		if (rd_valid === 1'b1)
			check("read", rd_data, exp_q.pop_front());
	end
	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		exp_q.push_back(exp);
		host.rd_reg(off);
	endtask
	// Pseudo-random source for the plug impedances.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [2:0] bin(input logic [15:0] z);
		return (z >= 16'h0AF0) ? 3'h7 : 3'(z / 16'h0190);
	endfunction
	// ==========================================================
	// Main sequence: register access, then a table of plugs and random ones.
	initial
	begin
		logic [15:0] ts_tab [4] = '{16'h01F4, 16'h0064, 16'h0BB8, 16'h03E8};
		logic [15:0] tr_tab [4] = '{16'h01F4, 16'h03E8, 16'h0000, 16'h0064};
		logic [7:0]  flg, ctl;
		logic [3:0]  esw, nsw;
		logic [2:0]  bt, br;
		logic        gl;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h08, 8'h00);
		host.wr_reg(8'h06, 8'hFF);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h00);
		host.wr_reg(8'h07, 8'hFF);
		rd(8'h07, 8'h1B);
		host.wr_reg(8'h07, 8'h00);
		esw = 4'h0;
		for (int i = 0; i < 9; i++)
		begin
			seed = lfsr(seed);
			ohms_ts <= (i < 4) ? ts_tab[i] : {4'h0, seed[11:0]};
			ohms_tr <= (i < 4) ? tr_tab[i] : {4'h0, seed[27:16]};
			bt = bin((i < 4) ? ts_tab[i] : {4'h0, seed[11:0]});
			br = bin((i < 4) ? tr_tab[i] : {4'h0, seed[27:16]});
			// Pass 6 starts detection from the host trigger bit instead of the pin.
			ctl = (i == 4) ? 8'h02 : ((i == 5) ? 8'h04 : {7'h0, i == 6});
			gl = (bt <= br);
			flg = ((bt > br ? bt : br) == 3'h7) ? 8'h08 : 8'h02;
			nsw = (bt < br) ? 4'h9 : 4'h6;
			if (bt == br)
			begin
				flg = 8'h01;
				nsw = 4'h3;
			end
			if (flg == 8'h08)
				nsw = 4'h0;
			if (!ctl[1])
				esw = nsw;
			host.wr_reg(8'h04, ctl);
			det_trigger <= !ctl[0];
			for (int k = 0; k < 300 && host_irq !== 1'b1; k++)
				@(posedge core_clk);
			det_trigger <= 1'b0;
			if (host_irq !== 1'b1)
			begin
				err_count++;
				summarize();
			end
			repeat (2) @(posedge core_clk);
			check("switches", {4'h0, sw}, {4'h0, esw});
			check("irq", {7'h0, host_irq}, 8'h01);
			check("indicator", {7'h0, ind_n}, {7'h0, !(ctl[2] || flg == 8'h02)});
			host.wr_reg(8'h07, flg);
			check("masked irq", {7'h0, host_irq}, 8'h00);
			host.wr_reg(8'h07, 8'h10);
			check("released", {6'h0, ind_n, host_irq}, 8'h03);
			host.wr_reg(8'h07, 8'h00);
			rd(8'h05, {1'b0, gl, bt, br});
			rd(8'h06, flg);
			check("cleared irq", {7'h0, host_irq}, 8'h00);
		end
		// A reset in mid-run must clear registers that hold live data.
		host.wr_reg(8'h07, 8'h1B);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(8'h05, 8'h00);
		rd(8'h07, 8'h00);
		summarize();
	end
endmodule // tb_headset_detect_status_regs
`default_nettype wire

// ### testbench/two_wire_host_model.sv
// Behavioural two-wire bus host that writes and reads the detector registers.
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_model (
	// Bench clock.
	input  wire logic       core_clk,
	// Bus lines; sda_line is the wired level of all parties.
	input  wire logic       sda_line,
	output logic            scl,
	output logic            sda_host,
	// Byte of each register read, valid for one cycle.
	output logic [7:0]      rd_data,
	output logic            rd_valid
);
	// ==========================================================
	// Idle bus at time zero.
	initial
	begin
		scl = 1'b1;
		sda_host = 1'b1;
		rd_data = 8'h00;
		rd_valid = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Phases last five cycles, above the four the slave needs to see them.
	task automatic frame(input logic a, input logic b);
		sda_host <= a;
		hold(3);
		scl <= 1'b1;
		hold(5);
		sda_host <= b;
		hold(5);
	endtask
	task automatic start();
		frame(1'b1, 1'b0);
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic put_bit(input logic b);
		frame(b, b);
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic get_bit(output logic b);
		sda_host <= 1'b1;
		hold(3);
		scl <= 1'b1;
		hold(3);
		b = sda_line;
		hold(2);
		scl <= 1'b0;
		hold(2);
	endtask
	// Acknowledge bits are clocked but not judged here.
	task automatic send(input logic [7:0] d);
		logic ack;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(ack);
	endtask
	task automatic wr_reg(input logic [7:0] off, input logic [7:0] d);
		start();
		send({headset_detect_pkg::SLAVE_ADDRESS_LOW, 1'b0});
		send(off);
		send(d);
		frame(1'b0, 1'b1);
	endtask
	// Single byte read with repeated start; the final not-acknowledge ends the burst.
	task automatic rd_reg(input logic [7:0] off);
		logic [7:0] b;
		start();
		send({headset_detect_pkg::SLAVE_ADDRESS_LOW, 1'b0});
		send(off);
		start();
		send({headset_detect_pkg::SLAVE_ADDRESS_LOW, 1'b1});
		for (int i = 7; i >= 0; i--)
			get_bit(b[i]);
		rd_data <= b;
		rd_valid <= 1'b1;
		hold(1);
		rd_valid <= 1'b0;
		put_bit(1'b1);
		frame(1'b0, 1'b1);
	endtask
endmodule // two_wire_host_model
`default_nettype wire
